// *** hw/instruction_cycle_sequencer_pkg.sv ***
// Shared constants and types for the instruction cycle sequencer
`default_nettype none
package instruction_cycle_sequencer_pkg;
   localparam int PHASE_W = 2;
   localparam logic [PHASE_W-1:0] LAST_PHASE = 2'h3;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int BIT_W = 3;
   localparam int PCL_W = 8;
   localparam int STACK_DEPTH = 4;
   localparam int SP_W = 2;
   localparam int FLAG_W = 4;
   localparam int FLAG_Z = 0;
   localparam int FLAG_C = 1;
   localparam int FLAG_AC = 2;
   localparam int FLAG_OV = 3;
   localparam logic [ADDR_W-1:0] RESET_VECTOR = 11'h000;
   localparam logic [ADDR_W-1:0] PC_STEP = 11'h001;
   localparam logic [ADDR_W-1:0] SKIP_STEP = 11'h002;
   localparam logic [SP_W-1:0] SP_STEP = 2'h1;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [4:0] NIBBLE_CARRY = 5'h10;
   localparam logic [FLAG_W-1:0] MASK_NONE = 4'h0;
   localparam logic [FLAG_W-1:0] MASK_Z = 4'h1;
   localparam logic [FLAG_W-1:0] MASK_C = 4'h2;
   localparam logic [FLAG_W-1:0] MASK_ARITH = 4'hF;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_MOV_M_TO_W = 5'h01, OP_MOV_W_TO_M = 5'h02,
      OP_MOV_IMM = 5'h03, OP_ADD = 5'h04, OP_ADC = 5'h05,
      OP_SUB = 5'h06, OP_SBC = 5'h07, OP_AND = 5'h08,
      OP_OR = 5'h09, OP_XOR = 5'h0A, OP_CPL = 5'h0B,
      OP_INC = 5'h0C, OP_DEC = 5'h0D, OP_RR = 5'h0E,
      OP_RL = 5'h0F, OP_RRC = 5'h10, OP_RLC = 5'h11,
      OP_BIT_SET = 5'h12, OP_BIT_CLR = 5'h13, OP_SKIP_ZERO = 5'h14,
      OP_SKIP_BIT_SET = 5'h15, OP_SKIP_BIT_CLR = 5'h16, OP_JMP = 5'h17,
      OP_CALL = 5'h18, OP_RET = 5'h19, OP_INTERRUPT_BACK = 5'h1A,
      OP_TBL_RD = 5'h1B, OP_HALT = 5'h1C
   } op_t;
endpackage : instruction_cycle_sequencer_pkg
`default_nettype wire

// *** hw/alu_if.sv ***
// Request and answer signals between the sequencer and its data path
`timescale 1ns/1ns
`default_nettype none
interface alu_if;
   import instruction_cycle_sequencer_pkg::*;
   op_t op;
   logic [DATA_W-1:0] a;
   logic [DATA_W-1:0] b;
   logic cin;
   logic [BIT_W-1:0] bit_sel;
   logic dest_mem;
   logic [DATA_W-1:0] result;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] flag_mask;
   logic wr;
   logic to_mem;
   logic skip;
   modport core (output op, a, b, cin, bit_sel, dest_mem,
      input result, flags, flag_mask, wr, to_mem, skip);
   modport dp (input op, a, b, cin, bit_sel, dest_mem,
      output result, flags, flag_mask, wr, to_mem, skip);
endinterface : alu_if
`default_nettype wire

// *** hw/byte_alu.sv ***
// Combinational data path: moves, arithmetic, logic, rotates, bit ops, tests
`timescale 1ns/1ns
`default_nettype none
module byte_alu
   import instruction_cycle_sequencer_pkg::*;
(
   alu_if.dp port
);
   logic [DATA_W:0] wide;
   logic [4:0] nib;
   logic [DATA_W-1:0] bit_one;
   logic [DATA_W-1:0] r;

   always_comb begin
      wide = '0;
      nib = '0;
      bit_one = ONE_BYTE << port.bit_sel;
      r = ZERO_BYTE;
      port.flag_mask = MASK_NONE;
      port.flags = '0;
      port.wr = 1'b1;
      port.to_mem = port.dest_mem;
      port.skip = 1'b0;
      unique case (port.op)
         OP_MOV_M_TO_W, OP_MOV_IMM: begin
            r = port.b;
            port.to_mem = 1'b0;
         end
         OP_MOV_W_TO_M: begin
            r = port.a;
            port.to_mem = 1'b1;
         end
         OP_ADD, OP_ADC: begin
            wide = {1'b0, port.a} + {1'b0, port.b} + {8'h00, port.op == OP_ADC && port.cin};
            nib = {1'b0, port.a[3:0]} + {1'b0, port.b[3:0]} + {4'h0, port.op == OP_ADC && port.cin};
            r = wide[DATA_W-1:0];
            port.flags[FLAG_C] = wide[DATA_W];
            port.flags[FLAG_AC] = nib >= NIBBLE_CARRY;
            port.flags[FLAG_OV] = (port.a[7] == port.b[7]) && (r[7] != port.a[7]);
            port.flag_mask = MASK_ARITH;
         end
         OP_SUB, OP_SBC: begin
            // Carry here means a borrow occurred
            wide = {1'b0, port.a} - {1'b0, port.b} - {8'h00, port.op == OP_SBC && port.cin};
            nib = {1'b0, port.a[3:0]} - {1'b0, port.b[3:0]} - {4'h0, port.op == OP_SBC && port.cin};
            r = wide[DATA_W-1:0];
            port.flags[FLAG_C] = wide[DATA_W];
            port.flags[FLAG_AC] = nib[4];
            port.flags[FLAG_OV] = (port.a[7] != port.b[7]) && (r[7] != port.a[7]);
            port.flag_mask = MASK_ARITH;
         end
         OP_AND, OP_OR, OP_XOR, OP_CPL: begin
            unique case (port.op)
               OP_AND: r = port.a & port.b;
               OP_OR: r = port.a | port.b;
               OP_XOR: r = port.a ^ port.b;
               default: r = ~port.b;
            endcase
            port.flag_mask = MASK_Z;
         end
         OP_INC, OP_DEC: begin
            r = (port.op == OP_INC) ? port.b + ONE_BYTE : port.b - ONE_BYTE;
            port.flag_mask = MASK_Z;
         end
         OP_RR: r = {port.b[0], port.b[7:1]};
         OP_RL: r = {port.b[6:0], port.b[7]};
         OP_RRC, OP_RLC: begin
            r = (port.op == OP_RRC) ? {port.cin, port.b[7:1]} : {port.b[6:0], port.cin};
            port.flags[FLAG_C] = (port.op == OP_RRC) ? port.b[0] : port.b[7];
            port.flag_mask = MASK_C;
         end
         OP_BIT_SET, OP_BIT_CLR: begin
            // Whole byte rewritten, only the chosen bit differs
            r = (port.op == OP_BIT_SET) ? port.b | bit_one : port.b & ~bit_one;
            port.to_mem = 1'b1;
         end
         OP_SKIP_ZERO, OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR: begin
            port.wr = 1'b0;
            unique case (port.op)
               OP_SKIP_ZERO: port.skip = port.b == ZERO_BYTE;
               OP_SKIP_BIT_SET: port.skip = (port.b & bit_one) != ZERO_BYTE;
               default: port.skip = (port.b & bit_one) == ZERO_BYTE;
            endcase
         end
         default: port.wr = 1'b0;
      endcase
      port.result = r;
      port.flags[FLAG_Z] = r == ZERO_BYTE;
   end
endmodule : byte_alu
`default_nettype wire

// *** hw/instruction_cycle_sequencer.sv ***
// Instruction cycle sequencer: four-phase timing, one- or two-cycle execution
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_sequencer
   import instruction_cycle_sequencer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire op_t op,
   input wire logic [DATA_W-1:0] operand,
   input wire logic [BIT_W-1:0] bit_sel,
   input wire logic dest_mem,
   input wire logic dest_pcl,
   input wire logic [ADDR_W-1:0] target,
   input wire logic [DATA_W-1:0] prog_data,
   input wire logic wake,
   output logic [ADDR_W-1:0] prog_addr,
   output logic table_rd,
   output logic [PHASE_W-1:0] cycle_phase,
   output logic cycle_boundary,
   output logic exec_fire,
   output logic flush_slot,
   output logic mem_wr,
   output logic [DATA_W-1:0] mem_wr_data,
   output logic [DATA_W-1:0] acc,
   output logic [FLAG_W-1:0] status,
   output logic interrupt_return,
   output logic halted
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [PHASE_W-1:0] phase;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] prog_addr;
      logic flush;
      logic tbl_pend;
      logic table_rd;
      logic halted;
      logic wake_meta;
      logic wake_sync;
      logic [SP_W-1:0] sp;
      logic [STACK_DEPTH-1:0][ADDR_W-1:0] stack;
      logic [DATA_W-1:0] acc;
      logic [FLAG_W-1:0] flags;
      logic mem_wr;
      logic [DATA_W-1:0] mem_wr_data;
      logic boundary;
      logic exec_fire;
      logic interrupt_back;
   } seq_state_t;

   seq_state_t st;
   seq_state_t next_st;
   logic [ADDR_W-1:0] next_pc;
   logic [SP_W-1:0] pop_sp;

   // ************************************************************
   // Data path
   // ************************************************************
   alu_if alu_bus ();

   assign alu_bus.op = op;
   assign alu_bus.a = st.acc;
   assign alu_bus.b = operand;
   assign alu_bus.cin = st.flags[FLAG_C];
   assign alu_bus.bit_sel = bit_sel;
   assign alu_bus.dest_mem = dest_mem;

   byte_alu u_alu (
      .port(alu_bus)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_st = st;
      next_pc = st.pc + PC_STEP;
      pop_sp = st.sp - SP_STEP;
      next_st.mem_wr = 1'b0;
      next_st.boundary = 1'b0;
      next_st.exec_fire = 1'b0;
      next_st.interrupt_back = 1'b0;
      next_st.wake_meta = wake;
      next_st.wake_sync = st.wake_meta;
      next_st.phase = st.phase + 2'h1;
      if (st.phase == LAST_PHASE) begin
         next_st.boundary = 1'b1;
         if (st.halted) begin
            // Leave power-down only on a cycle edge so timing stays aligned
            if (st.wake_sync) begin
               next_st.halted = 1'b0;
            end
         end else if (st.tbl_pend) begin
            // Table byte is on the program port now; fetch pointer was kept
            next_st.acc = prog_data;
            next_st.tbl_pend = 1'b0;
            next_st.table_rd = 1'b0;
            next_st.prog_addr = st.pc;
         end else if (st.flush) begin
            // Prefetched word is stale after a transfer; this slot does nothing
            next_st.flush = 1'b0;
         end else begin
            next_st.exec_fire = 1'b1;
            unique case (op)
               OP_JMP: begin
                  next_pc = target;
                  next_st.flush = 1'b1;
               end
               OP_CALL: begin
                  next_st.stack[st.sp] = st.pc + PC_STEP;
                  next_st.sp = st.sp + SP_STEP;
                  next_pc = target;
                  next_st.flush = 1'b1;
               end
               OP_RET, OP_INTERRUPT_BACK: begin
                  next_st.sp = pop_sp;
                  next_pc = st.stack[pop_sp];
                  next_st.flush = 1'b1;
                  next_st.interrupt_back = op == OP_INTERRUPT_BACK;
               end
               OP_TBL_RD: begin
                  // Pointer page follows the current code page
                  next_st.tbl_pend = 1'b1;
                  next_st.table_rd = 1'b1;
               end
               OP_HALT: begin
                  next_st.halted = 1'b1;
               end
               OP_NOP: begin
                  next_st.exec_fire = 1'b1;
               end
               default: begin
                  if (alu_bus.wr && alu_bus.to_mem && dest_pcl) begin
                     // Low byte write acts as a jump within the page
                     next_pc = {st.pc[ADDR_W-1:PCL_W], alu_bus.result};
                     next_st.flush = 1'b1;
                  end else if (alu_bus.wr && alu_bus.to_mem) begin
                     next_st.mem_wr = 1'b1;
                     next_st.mem_wr_data = alu_bus.result;
                  end else if (alu_bus.wr) begin
                     next_st.acc = alu_bus.result;
                  end
                  next_st.flags = (st.flags & ~alu_bus.flag_mask)
                     | (alu_bus.flags & alu_bus.flag_mask);
                  if (alu_bus.skip) begin
                     next_pc = st.pc + SKIP_STEP;
                     next_st.flush = 1'b1;
                  end
               end
            endcase
            next_st.pc = next_pc;
            if (op == OP_TBL_RD) begin
               next_st.prog_addr = {st.pc[ADDR_W-1:PCL_W], operand};
            end else begin
               next_st.prog_addr = next_pc;
            end
         end
      end
      if (rst) begin
         next_st = '0;
         next_st.pc = RESET_VECTOR;
         next_st.prog_addr = RESET_VECTOR;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prog_addr = st.prog_addr;
   assign table_rd = st.table_rd;
   assign cycle_phase = st.phase;
   assign cycle_boundary = st.boundary;
   assign exec_fire = st.exec_fire;
   assign flush_slot = st.flush;
   assign mem_wr = st.mem_wr;
   assign mem_wr_data = st.mem_wr_data;
   assign acc = st.acc;
   assign status = st.flags;
   assign interrupt_return = st.interrupt_back;
   assign halted = st.halted;

endmodule : instruction_cycle_sequencer
`default_nettype wire

// *** sim/instruction_cycle_sequencer_assertions.sv ***
// Port-level checks for the instruction cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_sequencer_assertions
   import instruction_cycle_sequencer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic table_rd,
   input wire logic [PHASE_W-1:0] cycle_phase,
   input wire logic cycle_boundary,
   input wire logic exec_fire,
   input wire logic flush_slot,
   input wire logic mem_wr,
   input wire logic [DATA_W-1:0] acc,
   input wire logic halted
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ********************************
   // Slot sequences
   // ********************************
   sequence s_phases;
      cycle_phase == 2'h1 ##1 cycle_phase == 2'h2 ##1 cycle_phase == 2'h3 ##1 cycle_phase == 2'h0;
   endsequence
   // Three idle clocks after the firing edge, then the slot is gone
   sequence s_flush_rest;
      (flush_slot && !exec_fire) [*3] ##1 !flush_slot;
   endsequence
   sequence s_table_rest;
      (table_rd && !exec_fire) [*3] ##1 (!table_rd && !exec_fire);
   endsequence
   // ********************************
   // Assertions
   // ********************************
   a_phase_order: assert property (
      cycle_phase == 2'h0 |=> s_phases) else $error("phase order broken");
   a_boundary_pulse: assert property (
      cycle_phase == 2'h3 |=> cycle_boundary ##1 !cycle_boundary)
      else $error("boundary pulse misplaced");
   a_fire_boundary: assert property (
      exec_fire |-> cycle_boundary) else $error("execution off boundary");
   a_flush_window: assert property (
      $rose(flush_slot) |-> exec_fire ##1 s_flush_rest) else $error("flush slot wrong");
   a_table_window: assert property (
      $rose(table_rd) |-> exec_fire ##1 s_table_rest) else $error("table slot wrong");
   a_halt_quiet: assert property (
      halted && $past(halted) |-> !exec_fire && !mem_wr) else $error("activity while halted");
   a_mem_pulse: assert property (
      mem_wr |-> exec_fire ##1 !mem_wr) else $error("memory write misplaced");
   a_acc_moves: assert property (
      !$stable(acc) |-> exec_fire || $fell(table_rd)) else $error("working register drift");
endmodule : instruction_cycle_sequencer_assertions
bind instruction_cycle_sequencer instruction_cycle_sequencer_assertions
   u_instruction_cycle_sequencer_assertions (.clk(clk), .rst(rst), .table_rd(table_rd),
   .cycle_phase(cycle_phase), .cycle_boundary(cycle_boundary), .exec_fire(exec_fire),
   .flush_slot(flush_slot), .mem_wr(mem_wr), .acc(acc), .halted(halted));
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
   import instruction_cycle_sequencer_pkg::*;
   typedef struct packed {
      logic [7:0] acc;
      logic [10:0] pc;
      logic [7:0] f;
      logic ir;
      logic mw;
      logic [7:0] md;
   } note_t;
   logic clk = 1'h0;
   logic rst = 1'h1;
   op_t op = OP_NOP;
   logic [7:0] operand = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic dest_mem = 1'h0;
   logic dest_pcl = 1'h0;
   logic [10:0] target = 11'h000;
   logic [7:0] prog_data = 8'h00;
   logic wake = 1'h0;
   logic [10:0] prog_addr, pc, p;
   logic [1:0] cycle_phase;
   logic table_rd, cycle_boundary, exec_fire, flush_slot, mem_wr, interrupt_return, halted, c;
   logic [7:0] mem_wr_data, acc, d, r, a;
   logic [3:0] status;
   logic [8:0] s;
   logic [4:0] h;
   logic ci, v;
   int fail_count = 0;
   int samples_checked = 0;
   int i;
   note_t n;
   note_t notes[$];
   op_t ar [0:3] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC};
   op_t lg [0:3] = '{OP_AND, OP_OR, OP_XOR, OP_CPL};
   op_t rt [0:3] = '{OP_RR, OP_RL, OP_RRC, OP_RLC};
   op_t bt [0:1] = '{OP_BIT_SET, OP_BIT_CLR};

   instruction_cycle_sequencer u_instruction_cycle_sequencer (
      .clk(clk), .rst(rst), .op(op), .operand(operand), .bit_sel(bit_sel),
      .dest_mem(dest_mem), .dest_pcl(dest_pcl), .target(target), .prog_data(prog_data),
      .wake(wake), .prog_addr(prog_addr), .table_rd(table_rd), .cycle_phase(cycle_phase),
      .cycle_boundary(cycle_boundary), .exec_fire(exec_fire), .flush_slot(flush_slot),
      .mem_wr(mem_wr), .mem_wr_data(mem_wr_data), .acc(acc), .status(status),
      .interrupt_return(interrupt_return), .halted(halted));

   always #25 clk = ~clk;

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   function automatic logic [10:0] nx();
      return pc + PC_STEP;
   endfunction : nx

   // Waits for an accepting phase 3, notes the expectation, then drives the instruction
   task automatic ex(input op_t o, input logic [7:0] dv, input logic [2:0] b, input logic dm,
         input logic [10:0] t, input logic [7:0] ea, input logic [10:0] ep,
         input logic [7:0] f, input logic [7:0] md);
      int k;
      k = 0;
      while (!(cycle_phase === 2'h3 && flush_slot === 1'h0 && table_rd === 1'h0
            && halted === 1'h0)) begin
         @(negedge clk);
         k++;
         if (k > 200) begin
            fail_count++;
            final_report();
         end
      end
      notes.push_back('{ea, ep, f, o == OP_INTERRUPT_BACK, dm & ~dest_pcl, md});
      op = o;
      operand = dv;
      bit_sel = b;
      dest_mem = dm;
      target = t;
      a = ea;
      pc = ep;
      @(negedge clk);
   endtask : ex

   always @(negedge clk) begin
      if (rst === 1'h0 && exec_fire === 1'h1) begin
         if (notes.size() == 0) begin
            check("exec_fire", 1'h1, 1'h0);
         end else begin
            n = notes.pop_front();
            check("acc", acc, n.acc);
            check("prog_addr", prog_addr, n.pc);
            check("status", status & n.f[7:4], n.f[3:0]);
            check("interrupt_return", interrupt_return, n.ir);
            check("mem_wr", mem_wr, n.mw);
            check("mem_wr_data", mem_wr_data & {8{n.mw}}, n.md);
         end
      end
   end

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      void'($urandom(68));
      a = 8'h00;
      pc = 11'h000;
      c = 1'h0;
      repeat (10) @(negedge clk);
      // Looked at while reset still holds; the phase counter starts on the next edge
      check("reset", {prog_addr, acc, status, halted, cycle_phase}, 32'h0);
      rst = 1'h0;
      @(negedge clk);
      ex(OP_MOV_IMM, 8'h5A, 3'h0, 1'h0, 11'h000, 8'h5A, nx(), 8'h00, 8'h00);
      ex(OP_MOV_W_TO_M, 8'h00, 3'h0, 1'h1, 11'h000, a, nx(), 8'h00, a);
      ex(OP_MOV_M_TO_W, 8'hFF, 3'h0, 1'h0, 11'h000, 8'hFF, nx(), 8'h00, 8'h00);
      for (i = 0; i < 12; i++) begin
         d = (i == 0) ? 8'h01 : 8'($urandom);
         // Odd entries take carry in; entries 2 and 3 of each four subtract, carry meaning borrow
         ci = (i % 2 == 1) && c;
         if (i % 4 < 2) begin
            s = {1'h0, a} + {1'h0, d} + {8'h00, ci};
            h = {1'h0, a[3:0]} + {1'h0, d[3:0]} + {4'h0, ci};
         end else begin
            s = {1'h0, a} - {1'h0, d} - {8'h00, ci};
            h = {1'h0, a[3:0]} - {1'h0, d[3:0]} - {4'h0, ci};
         end
         c = s[8];
         v = (s[7] != a[7]) && ((a[7] ^ d[7]) == (i % 4 > 1));
         ex(ar[i % 4], d, 3'h0, 1'h0, 11'h000, s[7:0], nx(),
            {4'hF, v, h[4], c, s[7:0] == 8'h00}, 8'h00);
      end
      for (i = 0; i < 4; i++) begin
         d = (i == 0) ? ~a : 8'($urandom);
         case (i)
            0: r = a & d;
            1: r = a | d;
            2: r = a ^ d;
            default: r = ~d;
         endcase
         ex(lg[i], d, 3'h0, 1'h0, 11'h000, r, nx(), {4'h3, 2'h0, c, r == 8'h00}, 8'h00);
      end
      d = 8'($urandom);
      ex(OP_INC, d, 3'h0, 1'h0, 11'h000, d + ONE_BYTE, nx(), {7'h08, d == 8'hFF}, 8'h00);
      ex(OP_DEC, 8'h01, 3'h0, 1'h1, 11'h000, a, nx(), 8'h11, 8'h00);
      for (i = 0; i < 4; i++) begin
         d = 8'($urandom);
         case (i)
            0: r = {d[0], d[7:1]};
            1: r = {d[6:0], d[7]};
            2: r = {c, d[7:1]};
            default: r = {d[6:0], c};
         endcase
         c = (i == 2) ? d[0] : (i == 3) ? d[7] : c;
         ex(rt[i], d, 3'h0, 1'h0, 11'h000, r, nx(), {6'h08, c, 1'h0}, 8'h00);
      end
      for (i = 0; i < 16; i++) begin
         d = 8'($urandom);
         r = d;
         r[i % 8] = (i < 8);
         ex(bt[i / 8], d, 3'(i), 1'h1, 11'h000, a, nx(), 8'h00, r);
      end
      ex(OP_SKIP_ZERO, 8'h00, 3'h0, 1'h0, 11'h000, a, pc + SKIP_STEP, 8'h00, 8'h00);
      ex(OP_SKIP_ZERO, 8'h05, 3'h0, 1'h0, 11'h000, a, nx(), 8'h00, 8'h00);
      ex(OP_SKIP_BIT_SET, 8'h10, 3'h4, 1'h0, 11'h000, a, pc + SKIP_STEP, 8'h00, 8'h00);
      ex(OP_SKIP_BIT_CLR, 8'h10, 3'h4, 1'h0, 11'h000, a, nx(), 8'h00, 8'h00);
      ex(OP_JMP, 8'h00, 3'h0, 1'h0, 11'h234, a, 11'h234, 8'h00, 8'h00);
      ex(OP_CALL, 8'h00, 3'h0, 1'h0, 11'h400, a, 11'h400, 8'h00, 8'h00);
      ex(OP_CALL, 8'h00, 3'h0, 1'h0, 11'h500, a, 11'h500, 8'h00, 8'h00);
      ex(OP_RET, 8'h00, 3'h0, 1'h0, 11'h000, a, 11'h401, 8'h00, 8'h00);
      ex(OP_RET, 8'h00, 3'h0, 1'h0, 11'h000, a, 11'h235, 8'h00, 8'h00);
      ex(OP_CALL, 8'h00, 3'h0, 1'h0, 11'h600, a, 11'h600, 8'h00, 8'h00);
      ex(OP_INTERRUPT_BACK, 8'h00, 3'h0, 1'h0, 11'h000, a, 11'h236, 8'h00, 8'h00);
      dest_pcl = 1'h1;
      ex(OP_MOV_W_TO_M, 8'h00, 3'h0, 1'h1, 11'h000, a, {pc[10:8], a}, 8'h00, 8'h00);
      dest_pcl = 1'h0;
      prog_data = 8'($urandom);
      p = pc;
      ex(OP_TBL_RD, 8'h77, 3'h0, 1'h0, 11'h000, a, {pc[10:8], 8'h77}, 8'h00, 8'h00);
      pc = p + PC_STEP;
      ex(OP_NOP, 8'h00, 3'h0, 1'h0, 11'h000, prog_data, nx(), 8'h00, 8'h00);
      ex(OP_HALT, 8'h00, 3'h0, 1'h0, 11'h000, a, nx(), 8'h00, 8'h00);
      repeat (12) @(negedge clk);
      check("halted", halted, 1'h1);
      wake = 1'h1;
      ex(OP_NOP, 8'h00, 3'h0, 1'h0, 11'h000, a, nx(), 8'h00, 8'h00);
      wake = 1'h0;
      // Park in halt so the held opcode cannot fire again
      ex(OP_HALT, 8'h00, 3'h0, 1'h0, 11'h000, a, nx(), 8'h00, 8'h00);
      i = 0;
      while (notes.size() > 0 && i < 100) begin
         @(negedge clk);
         i++;
      end
      check("pending notes", notes.size(), 32'h0);
      final_report();
   end
endmodule : tb
`default_nettype wire
